// *** rtl/pcx_pkg.sv ***
// Package: register map, field positions, reset values and timing for the crossbar configuration block
package pcx_pkg;

    // ------------------------------------------------------------
    // Register addresses on the special function register port
    // ------------------------------------------------------------
    localparam logic [7:0] PCX_ADDR_ROUTE_A   = 8'hE1;
    localparam logic [7:0] PCX_ADDR_ROUTE_B   = 8'hE2;
    localparam logic [7:0] PCX_ADDR_ROUTE_C   = 8'hE3;
    localparam logic [7:0] PCX_ADDR_DRIVE     = 8'hF6;
    localparam logic [7:0] PCX_ADDR_P0_MATCH  = 8'hFD;
    localparam logic [7:0] PCX_ADDR_P0_SELECT = 8'hFE;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PCX_RST_ROUTE_A   = 8'h00;
    localparam logic [7:0] PCX_RST_ROUTE_B   = 8'h00;
    localparam logic [7:0] PCX_RST_ROUTE_C   = 8'h00;
    localparam logic [7:0] PCX_RST_DRIVE     = 8'h07;
    localparam logic [7:0] PCX_RST_P0_MATCH  = 8'hFF;
    localparam logic [7:0] PCX_RST_P0_SELECT = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PCX_A_SYS_CLOCK   = 7;
    localparam int PCX_A_CMP1_ASYNC  = 6;
    localparam int PCX_A_CMP1_SYNC   = 5;
    localparam int PCX_A_CMP0_ASYNC  = 4;
    localparam int PCX_A_CMP0_SYNC   = 3;
    localparam int PCX_A_TWO_WIRE    = 2;
    localparam int PCX_A_SERIAL_PER  = 1;
    localparam int PCX_A_ASYNC_SER   = 0;
    localparam int PCX_B_TIMER_LSB   = 3;   // timer zero, one, two at 3, 4, 5
    localparam int PCX_B_TIMER_MSB   = 5;
    localparam int PCX_B_CNT_EXT     = 2;
    localparam int PCX_B_CHAN_MSB    = 1;   // channel field 1:0
    localparam int PCX_C_PULL_DIS    = 7;
    localparam int PCX_C_XBAR_EN     = 6;
    localparam int PCX_D_DRIVE_MSB   = 2;   // port 2, 1, 0 at 2, 1, 0

    // ------------------------------------------------------------
    // Serial peripheral pin counts and synchroniser depth
    // ------------------------------------------------------------
    localparam logic [2:0] PCX_SPI_PINS_3WIRE = 3'h3;
    localparam logic [2:0] PCX_SPI_PINS_4WIRE = 3'h4;
    localparam int         PCX_SYNC_STAGES    = 2;

endpackage

// *** rtl/pcx_match_if.sv ***
// Interface: port 0 compare configuration and result between the register core and the comparator
`timescale 1ns/1ps
interface pcx_match_if;
    logic [7:0] select;      // Pins taking part in the compare
    logic [7:0] expected;    // Expected level per pin
    logic [7:0] pin_level;   // Synchronised pin levels
    logic       mismatch;    // Combinational mismatch result

    modport cfg (output select, output expected, output pin_level, input mismatch);
    modport cmp (input select, input expected, input pin_level, output mismatch);
endinterface

// *** rtl/pcx_sync.sv ***
// Two flip-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module pcx_sync
    import pcx_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         ref_clk,   // System clock
    input  wire logic         rst_n,     // Asynchronous reset, active low
    input  wire logic [W-1:0] async_in,  // Levels from outside the domain
    output logic      [W-1:0] sync_out   // Levels safe to read
);

    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= '0;
            stable_q <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule

// *** rtl/pcx_match.sv ***
// Port 0 masked pattern comparator
`timescale 1ns/1ps
module pcx_match (
    pcx_match_if.cmp port_if   // Compare configuration and result
);

    // A pin counts only when selected; its level is held against the expected value
    assign port_if.mismatch = ((port_if.pin_level & port_if.select)
                               != (port_if.expected & port_if.select));

endmodule

// *** rtl/pcx_crossbar_cfg.sv ***
// Crossbar routing, pull-up, drive strength and port 0 match configuration core
`timescale 1ns/1ps

// Summary of operation
// - Routing bit 7 routes system clock out
// - Bit 6 routes comparator one async output
// - Bit 5 routes comparator one sync output
// - Bit 4 routes comparator zero async output
// - Bit 3 routes comparator zero sync output
// - Bit 2 routes both two-wire bus signals
// - Bit 1 routes serial peripheral, 3 or 4 pins
// - Bit 0 routes UART to P0.4, P0.5
// - Timer inputs two, one, zero at 5,4,3
// - Bit 2 routes counter array external input
// - Channel field routes none, 0, 0-1, 0-2
// - Pull-up disable bit turns weak pull-ups off
// - Drive bits select high drive per port
// - Selected port 0 pins compared with match
// - Crossbar disabled keeps all pin drivers off
// - Masked pins differing from match raise mismatch
// - Mismatch serves as interrupt and wake-up
// - Match bit gives expected pin level
module pcx_crossbar_cfg
    import pcx_pkg::*;
(
    input  wire logic       ref_clk,              // System clock, 200 MHz
    input  wire logic       rst_n,                // Asynchronous reset, active low
    input  wire logic [7:0] sfr_addr,             // Register address
    input  wire logic       sfr_wr_en,            // Write strobe, one cycle
    input  wire logic       sfr_rd_en,            // Read strobe, one cycle
    input  wire logic [7:0] sfr_wdata,            // Write data
    output logic      [7:0] sfr_rdata_q,          // Read data, valid one cycle after strobe
    input  wire logic [7:0] p0_pin_level,         // Port 0 pad levels, asynchronous
    input  wire logic [7:0] p0_digital_mode,      // Port 0 digital mode per pin, 0 is analog
    input  wire logic       spi_nss_in_use,       // Serial peripheral uses its slave select
    output logic            route_sys_clock_q,    // System clock owns a pin
    output logic            route_cmp1_async_q,   // Comparator one async output owns a pin
    output logic            route_cmp1_sync_q,    // Comparator one sync output owns a pin
    output logic            route_cmp0_async_q,   // Comparator zero async output owns a pin
    output logic            route_cmp0_sync_q,    // Comparator zero sync output owns a pin
    output logic            route_two_wire_q,     // Both two-wire bus signals own pins
    output logic [2:0]      spi_pin_count_q,      // Pins taken by serial peripheral: 0, 3 or 4
    output logic            route_uart_q,         // UART transmit on P0.4, receive on P0.5
    output logic [2:0]      route_timer_q,        // Timer two, one, zero inputs own pins
    output logic            route_counter_ext_q,  // Counter array external input owns a pin
    output logic [2:0]      route_counter_chan_q, // Counter channel two, one, zero outputs
    output logic            pin_drivers_en_q,     // High and low output drivers allowed
    output logic [7:0]      p0_pullup_en_q,       // Weak pull-up enable per port 0 pin
    output logic [2:0]      drive_high_q,         // High drive for port 2, 1, 0
    output logic            mismatch_q,           // Port mismatch level
    output logic            mismatch_irq_q,       // Interrupt request, level
    output logic            mismatch_wake_q       // Wake-up pulse on mismatch onset
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] route_a_q;
    logic [5:0] route_b_q;
    logic       pull_dis_q;
    logic       xbar_en_q;
    logic [2:0] drive_q;
    logic [7:0] p0_match_q;
    logic [7:0] p0_select_q;
    logic [7:0] p0_sync;
    logic [2:0] chan_d;

    pcx_match_if match_if ();

    // Register writes; reserved bits are not stored
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_a_q   <= PCX_RST_ROUTE_A;
            route_b_q   <= PCX_RST_ROUTE_B[5:0];
            pull_dis_q  <= PCX_RST_ROUTE_C[PCX_C_PULL_DIS];
            xbar_en_q   <= PCX_RST_ROUTE_C[PCX_C_XBAR_EN];
            drive_q     <= PCX_RST_DRIVE[2:0];
            p0_match_q  <= PCX_RST_P0_MATCH;
            p0_select_q <= PCX_RST_P0_SELECT;
        end
        else if (sfr_wr_en)
        begin
            if (sfr_addr == PCX_ADDR_ROUTE_A)
            begin
                route_a_q <= sfr_wdata;
            end
            else if (sfr_addr == PCX_ADDR_ROUTE_B)
            begin
                route_b_q <= sfr_wdata[5:0];
            end
            else if (sfr_addr == PCX_ADDR_ROUTE_C)
            begin
                pull_dis_q <= sfr_wdata[PCX_C_PULL_DIS];
                xbar_en_q  <= sfr_wdata[PCX_C_XBAR_EN];
            end
            else if (sfr_addr == PCX_ADDR_DRIVE)
            begin
                drive_q <= sfr_wdata[2:0];
            end
            else if (sfr_addr == PCX_ADDR_P0_MATCH)
            begin
                p0_match_q <= sfr_wdata;
            end
            else if (sfr_addr == PCX_ADDR_P0_SELECT)
            begin
                p0_select_q <= sfr_wdata;
            end
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfr_rdata_q <= 8'h00;
        end
        else if (sfr_rd_en)
        begin
            if (sfr_addr == PCX_ADDR_ROUTE_A)
            begin
                sfr_rdata_q <= route_a_q;
            end
            else if (sfr_addr == PCX_ADDR_ROUTE_B)
            begin
                sfr_rdata_q <= {2'h0, route_b_q};
            end
            else if (sfr_addr == PCX_ADDR_ROUTE_C)
            begin
                sfr_rdata_q <= {pull_dis_q, xbar_en_q, 6'h00};
            end
            else if (sfr_addr == PCX_ADDR_DRIVE)
            begin
                sfr_rdata_q <= {5'h00, drive_q};
            end
            else if (sfr_addr == PCX_ADDR_P0_MATCH)
            begin
                sfr_rdata_q <= p0_match_q;
            end
            else if (sfr_addr == PCX_ADDR_P0_SELECT)
            begin
                sfr_rdata_q <= p0_select_q;
            end
            else
            begin
                sfr_rdata_q <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral routing
    // ------------------------------------------------------------

    // Thermometer decode of the counter channel field
    always_comb
    begin
        case (route_b_q[PCX_B_CHAN_MSB:0])
            2'h0:    chan_d = 3'h0;
            2'h1:    chan_d = 3'h1;
            2'h2:    chan_d = 3'h3;
            default: chan_d = 3'h7;
        endcase
    end

    // Nothing takes a pin while the crossbar is off or its bit is clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_sys_clock_q    <= 1'b0;
            route_cmp1_async_q   <= 1'b0;
            route_cmp1_sync_q    <= 1'b0;
            route_cmp0_async_q   <= 1'b0;
            route_cmp0_sync_q    <= 1'b0;
            route_two_wire_q     <= 1'b0;
            spi_pin_count_q      <= 3'h0;
            route_uart_q         <= 1'b0;
            route_timer_q        <= 3'h0;
            route_counter_ext_q  <= 1'b0;
            route_counter_chan_q <= 3'h0;
        end
        else
        begin
            route_sys_clock_q    <= xbar_en_q & route_a_q[PCX_A_SYS_CLOCK];
            route_cmp1_async_q   <= xbar_en_q & route_a_q[PCX_A_CMP1_ASYNC];
            route_cmp1_sync_q    <= xbar_en_q & route_a_q[PCX_A_CMP1_SYNC];
            route_cmp0_async_q   <= xbar_en_q & route_a_q[PCX_A_CMP0_ASYNC];
            route_cmp0_sync_q    <= xbar_en_q & route_a_q[PCX_A_CMP0_SYNC];
            route_two_wire_q     <= xbar_en_q & route_a_q[PCX_A_TWO_WIRE];
            if (xbar_en_q && route_a_q[PCX_A_SERIAL_PER])
            begin
                spi_pin_count_q <= spi_nss_in_use ? PCX_SPI_PINS_4WIRE
                                                  : PCX_SPI_PINS_3WIRE;
            end
            else
            begin
                spi_pin_count_q <= 3'h0;
            end
            route_uart_q         <= xbar_en_q & route_a_q[PCX_A_ASYNC_SER];
            route_timer_q        <= {3{xbar_en_q}}
                                    & route_b_q[PCX_B_TIMER_MSB:PCX_B_TIMER_LSB];
            route_counter_ext_q  <= xbar_en_q & route_b_q[PCX_B_CNT_EXT];
            route_counter_chan_q <= {3{xbar_en_q}} & chan_d;
        end
    end

    // ------------------------------------------------------------
    // Pad controls
    // ------------------------------------------------------------

    // Drivers, pull-ups and drive strength
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_drivers_en_q <= 1'b0;
            p0_pullup_en_q   <= 8'h00;
            drive_high_q     <= PCX_RST_DRIVE[2:0];
        end
        else
        begin
            pin_drivers_en_q <= xbar_en_q;
            p0_pullup_en_q   <= {8{~pull_dis_q}} & p0_digital_mode;
            drive_high_q     <= drive_q;
        end
    end

    // ------------------------------------------------------------
    // Port 0 match
    // ------------------------------------------------------------

    // Pad levels cross into the clock domain first
    pcx_sync #(
        .W (8)
    ) u_p0_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (p0_pin_level),
        .sync_out (p0_sync)
    );

    assign match_if.select    = p0_select_q;
    assign match_if.expected  = p0_match_q;
    assign match_if.pin_level = p0_sync;

    pcx_match u_match (
        .port_if (match_if)
    );

    // Mismatch level, interrupt request and onset wake pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mismatch_q      <= 1'b0;
            mismatch_irq_q  <= 1'b0;
            mismatch_wake_q <= 1'b0;
        end
        else
        begin
            mismatch_q      <= match_if.mismatch;
            mismatch_irq_q  <= match_if.mismatch;
            mismatch_wake_q <= match_if.mismatch & ~mismatch_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic wr_a;
    assign wr_a = sfr_wr_en && (sfr_addr == PCX_ADDR_ROUTE_A);

    AST_SYS_CLOCK_ROUTE: assert property (
        wr_a && xbar_en_q |=> ##1 (route_sys_clock_q == $past(sfr_wdata[PCX_A_SYS_CLOCK], 2)))
        else $error("system clock route does not follow written bit");

    AST_CMP_ROUTES: assert property (
        route_cmp1_async_q |-> $past(xbar_en_q && route_a_q[PCX_A_CMP1_ASYNC]))
        else $error("comparator one async routed without its bit");

    AST_CMP_SYNC_ROUTES: assert property (
        (route_cmp1_sync_q == $past(xbar_en_q & route_a_q[PCX_A_CMP1_SYNC]))
        && (route_cmp0_sync_q == $past(xbar_en_q & route_a_q[PCX_A_CMP0_SYNC]))
        && (route_cmp0_async_q == $past(xbar_en_q & route_a_q[PCX_A_CMP0_ASYNC])))
        else $error("comparator sync or async route wrong");

    AST_SPI_PINS: assert property (
        (spi_pin_count_q != 3'h0) |-> ((spi_pin_count_q == PCX_SPI_PINS_3WIRE)
                                       || (spi_pin_count_q == PCX_SPI_PINS_4WIRE)))
        else $error("serial peripheral pin count not 3 or 4");

    AST_CHANNEL_THERMO: assert property (
        route_counter_chan_q inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("counter channel routing not contiguous from channel 0");

    AST_DRIVERS_OFF: assert property (
        !xbar_en_q [*2] |-> !pin_drivers_en_q && !route_uart_q && !route_two_wire_q
                            && (route_timer_q == 3'h0) && (spi_pin_count_q == 3'h0))
        else $error("pin driven while crossbar disabled");

    AST_PULLUP_OFF: assert property (
        $past(pull_dis_q) |-> (p0_pullup_en_q == 8'h00))
        else $error("weak pull-up on while globally disabled");

    AST_MISMATCH: assert property (
        mismatch_q == (($past(p0_pin_level, 3) & $past(p0_select_q))
                       != ($past(p0_match_q) & $past(p0_select_q))))
        else $error("mismatch level wrong for stable pins");

    AST_NO_SELECT: assert property (
        ($past(p0_select_q) == 8'h00) |-> !mismatch_q)
        else $error("mismatch with no pin selected");

    AST_WAKE_ONSET: assert property (
        mismatch_wake_q |-> mismatch_q && !$past(mismatch_q) && mismatch_irq_q)
        else $error("wake pulse not at mismatch onset");

    AST_DRIVE_FOLLOWS: assert property (
        drive_high_q == $past(drive_q))
        else $error("drive strength does not follow its register");

    AST_TIMER_ROUTE: assert property (
        route_timer_q == $past({3{xbar_en_q}} & route_b_q[PCX_B_TIMER_MSB:PCX_B_TIMER_LSB]))
        else $error("timer input routing does not follow its bits");

    AST_UART_TWO_WIRE: assert property (
        (route_uart_q == $past(xbar_en_q & route_a_q[PCX_A_ASYNC_SER]))
        && (route_two_wire_q == $past(xbar_en_q & route_a_q[PCX_A_TWO_WIRE])))
        else $error("uart or two-wire routing does not follow its bit");

    COV_UART_ROUTED:   cover property (route_uart_q && pin_drivers_en_q);
    COV_SPI_FOUR:      cover property (spi_pin_count_q == PCX_SPI_PINS_4WIRE);
    COV_ALL_CHANNELS:  cover property (route_counter_chan_q == 3'h7);
    COV_MISMATCH_WAKE: cover property (mismatch_wake_q);

endmodule

// *** rtl/_unused_placeholder_removed.sv ***
// Empty design note file holding nothing else

// *** tb/pcx_pin_model.sv ***
// Port 0 pad model: external drivers, weak pull-ups, floating pattern
`timescale 1ns/1ps
module pcx_pin_model (
    input  wire logic       ref_clk,   // System clock
    input  wire logic [7:0] ext_val,   // External driver level
    input  wire logic [7:0] ext_en,    // External driver active
    input  wire logic [7:0] pullup_en, // Weak pull-up from block
    output logic      [7:0] pad_level  // Pad level seen by block
);
    logic [7:0] float_q; // Undriven pads change every cycle
    initial float_q = 8'h55;
    // -----------------------------
    // Pad resolution
    // -----------------------------
    always @(negedge ref_clk) float_q <= ~float_q;
    // Driver wins, else pull-up, else pattern
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pad_level[i] = ext_en[i] ? ext_val[i] : (pullup_en[i] ? 1'b1 : float_q[i]);
    end
endmodule

// *** tb/pcx_crossbar_cfg_tb.sv ***
// Self-checking bench for crossbar routing and port 0 match
`timescale 1ns/1ps
module pcx_crossbar_cfg_tb;
    import pcx_pkg::*;
    logic       ref_clk, rst_n, wr, rd, nss;
    logic [7:0] addr, wdata, rdata, pins, dmode, ext_val, ext_en, pull;
    logic       r_sc, r_c1a, r_c1s, r_c0a, r_c0s, r_tw, r_ua, r_ext, drv_en, mm, irq, wake;
    logic [2:0] spi_n, tmr, chan, dhi;
    logic [7:0] a_vec, rd_v;
    int         fail_count, samples_checked;
    logic [7:0] ra [6] = '{PCX_ADDR_ROUTE_A, PCX_ADDR_ROUTE_B, PCX_ADDR_ROUTE_C,
                           PCX_ADDR_DRIVE, PCX_ADDR_P0_MATCH, PCX_ADDR_P0_SELECT};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'hFF, 8'h00};
    assign a_vec = {r_sc, r_c1a, r_c1s, r_c0a, r_c0s, r_tw, |spi_n, r_ua};
    // -----------------------------
    // Design and pad model
    // -----------------------------
    pcx_crossbar_cfg dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr_en(wr),
        .sfr_rd_en(rd), .sfr_wdata(wdata), .sfr_rdata_q(rdata), .p0_pin_level(pins),
        .p0_digital_mode(dmode), .spi_nss_in_use(nss), .route_sys_clock_q(r_sc),
        .route_cmp1_async_q(r_c1a), .route_cmp1_sync_q(r_c1s), .route_cmp0_async_q(r_c0a),
        .route_cmp0_sync_q(r_c0s), .route_two_wire_q(r_tw), .spi_pin_count_q(spi_n),
        .route_uart_q(r_ua), .route_timer_q(tmr), .route_counter_ext_q(r_ext),
        .route_counter_chan_q(chan), .pin_drivers_en_q(drv_en), .p0_pullup_en_q(pull),
        .drive_high_q(dhi), .mismatch_q(mm), .mismatch_irq_q(irq), .mismatch_wake_q(wake));
    pcx_pin_model pads (.ref_clk(ref_clk), .ext_val(ext_val), .ext_en(ext_en),
        .pullup_en(pull), .pad_level(pins));
    // -----------------------------
    // Shared tasks
    // -----------------------------
    always #2.5 ref_clk = ~ref_clk;
    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check_out(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Write strobe, then two edges for the routed outputs to follow
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a; wdata = d; wr = 1'b1;
        @(negedge ref_clk);
        wr = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        addr = a; rd = 1'b1;
        @(negedge ref_clk);
        rd = 1'b0;
        rd_v = rdata;
        samples_checked++;
        if (rd_v !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: read %h got %h want %h", $time, a, rd_v, exp);
        end
    endtask
    // -----------------------------
    // Scenarios
    // -----------------------------
    task automatic t_reset();
        for (int i = 0; i < 6; i++) check_reg(ra[i], rv[i]);
        check_reg(8'hE0, 8'h00);
        check_out({5'h00, dhi}, 8'h07, "drive reset");
        check_out(a_vec, 8'h00, "routes reset");
        check_out({7'h00, drv_en}, 8'h00, "drivers reset");
    endtask
    task automatic t_disabled();
        wr_reg(PCX_ADDR_ROUTE_A, 8'hFF);
        wr_reg(PCX_ADDR_ROUTE_B, 8'h3F);
        check_out(a_vec, 8'h00, "routes off");
        check_out({tmr, chan, r_ext, drv_en}, 8'h00, "b routes off");
    endtask
    task automatic t_route_a();
        wr_reg(PCX_ADDR_ROUTE_C, 8'h40);
        check_out({7'h00, drv_en}, 8'h01, "drivers on");
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(PCX_ADDR_ROUTE_A, 8'h01 << i);
            check_out(a_vec, 8'h01 << i, "route a bit");
        end
        wr_reg(PCX_ADDR_ROUTE_A, 8'h02);
        check_out({5'h00, spi_n}, 8'h03, "spi 3 pins");
        nss = 1'b1;
        repeat (3) @(negedge ref_clk);
        check_out({5'h00, spi_n}, 8'h04, "spi 4 pins");
        wr_reg(PCX_ADDR_ROUTE_A, 8'h00);
        check_out({5'h00, spi_n}, 8'h00, "spi off");
    endtask
    task automatic t_route_b();
        logic [2:0] ch_exp [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        for (int i = 3; i < 6; i++)
        begin
            wr_reg(PCX_ADDR_ROUTE_B, 8'h01 << i);
            check_out({5'h00, tmr}, 8'h01 << (i - 3), "timer route");
        end
        wr_reg(PCX_ADDR_ROUTE_B, 8'h04);
        check_out({1'b0, tmr, chan, r_ext}, 8'h01, "ext input");
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(PCX_ADDR_ROUTE_B, 8'(c));
            check_out({5'h00, chan}, {5'h00, ch_exp[c]}, "channels");
        end
    endtask
    task automatic t_pull_drive();
        dmode = 8'hF0;
        wr_reg(PCX_ADDR_ROUTE_C, 8'h40);
        check_out(pull, 8'hF0, "pull-ups on");
        wr_reg(PCX_ADDR_ROUTE_C, 8'hC0);
        check_out(pull, 8'h00, "pull-ups off");
        check_reg(PCX_ADDR_ROUTE_C, 8'hC0);
        dmode = 8'hFF;
        for (int v = 0; v < 8; v++)
        begin
            wr_reg(PCX_ADDR_DRIVE, 8'(v));
            check_out({5'h00, dhi}, 8'(v), "drive");
        end
    endtask
    task automatic t_match();
        int n;
        ext_en = 8'h0F; ext_val = 8'h05;
        wr_reg(PCX_ADDR_P0_SELECT, 8'h0F);
        wr_reg(PCX_ADDR_P0_MATCH, 8'h05);
        repeat (4) @(negedge ref_clk);
        check_out({7'h00, mm}, 8'h00, "match, free pads toggle");
        ext_val = 8'h07;
        for (n = 0; n < 8 && wake !== 1'b1; n++) @(negedge ref_clk);
        if (n == 8)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: no wake pulse", $time);
            test_done();
        end
        check_out({6'h00, mm, irq}, 8'h03, "mismatch");
        @(negedge ref_clk);
        check_out({6'h00, wake, irq}, 8'h01, "wake pulse");
        ext_val = 8'h05;
        repeat (5) @(negedge ref_clk);
        check_out({7'h00, mm}, 8'h00, "match again");
        wr_reg(PCX_ADDR_P0_MATCH, 8'h0D);
        check_out({7'h00, mm}, 8'h01, "expect high");
        wr_reg(PCX_ADDR_P0_SELECT, 8'h07);
        check_out({7'h00, mm}, 8'h00, "pin deselected");
    endtask
    // -----------------------------
    // Main sequence
    // -----------------------------
    initial
    begin
        ref_clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; nss = 1'b0;
        addr = 8'h00; wdata = 8'h00; dmode = 8'hFF; ext_val = 8'h00; ext_en = 8'h00;
        fail_count = 0; samples_checked = 0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_disabled();
        t_route_a();
        t_route_b();
        t_pull_drive();
        t_match();
        test_done();
    end
endmodule
